/* rlio_pkg.sv */
// Overview of operation
// RQ1: Card answers one switch-selected I/O address from 000H to 3F8H.
// RQ2: Factory switch setting places the port at 310H.
// RQ3: Writes load the latch and reads return it, same address.
// RQ4: Each latch bit drives its own relay by bit weight.
// RQ5: Bit off joins common to break contact; on joins make contact.
// RQ6: One indicator per relay, lit while that relay is on.
// RQ7: Green enable indicator lit only while relay drivers are enabled.
// RQ8: Host operates relays by writing a full eight-bit pattern.
// RQ9: Host should initialise the card soon after power-up.
// RQ10: Power-up and system reset force every relay off.
// RQ11: Drivers stay disabled after reset until a port read occurs.
// RQ12: Latch polarity is true: one turns relay on, zero off.
// RQ13: A port read returns the relay pattern held in the latch.
// RQ14: Decode ten address lines against switch; ignore memory cycles.
package rlio_pkg;
   localparam int rlio_addr_width = 10;
   localparam int rlio_data_width = 8;
   localparam logic [9:0] rlio_addr_min = 10'h000;
   localparam logic [9:0] rlio_addr_max = 10'h3f8;
   localparam logic [9:0] rlio_addr_shipped = 10'h310;
   localparam logic [7:0] rlio_latch_reset = 8'h00;
   localparam logic rlio_enable_reset = 1'b0;
endpackage : rlio_pkg

/* rlio_relay_latch.sv */
`timescale 1ns/1ps
module rlio_relay_latch (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // Address switch
   input wire logic [9:0] addr_switch_in,
   // Host expansion bus
   input wire logic [9:0] bus_addr_in,
   input wire logic bus_io_write_n_in,
   input wire logic bus_io_read_n_in,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe_out,
   // Relay drive
   output logic [7:0] relay_make_out,
   output logic [7:0] relay_break_out,
   // Indicators
   output logic [7:0] relay_led_out,
   output logic enable_led_out
);
   logic [9:0] addr_sync;
   logic [9:0] switch_sync;
   logic [7:0] data_sync;
   logic wr_n_sync;
   logic rd_n_sync;
   logic wr_prev;
   logic rd_prev;
   logic [7:0] relay_control_bits;
   logic drivers_enabled;
   logic hit;
   logic wr_active;
   logic rd_active;
   logic wr_strobe;
   logic rd_strobe;

   // Bus pins are asynchronous to our clock
   rlio_sync #(
      .width(10),
      .reset_value(10'h000)
   ) i_addr_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .async_in(bus_addr_in),
      .sync_out(addr_sync)
   );

   rlio_sync #(
      .width(8),
      .reset_value(8'h00)
   ) i_data_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .async_in(bus_data_in),
      .sync_out(data_sync)
   );

   // Strobes reset to their idle level, so no false edge after reset
   rlio_sync #(
      .width(1),
      .reset_value(1'b1)
   ) i_write_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .async_in(bus_io_write_n_in),
      .sync_out(wr_n_sync)
   );

   rlio_sync #(
      .width(1),
      .reset_value(1'b1)
   ) i_read_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .async_in(bus_io_read_n_in),
      .sync_out(rd_n_sync)
   );

   // Switch may be moved while powered, so it is synchronised too
   rlio_sync #(
      .width(10),
      .reset_value(rlio_pkg::rlio_addr_shipped) // RQ2
   ) i_switch_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .async_in(addr_switch_in),
      .sync_out(switch_sync)
   );

   // Only I/O strobes are seen, so memory cycles never match
   assign hit = (addr_sync == switch_sync); // RQ1 RQ14
   assign wr_active = ~wr_n_sync & hit;
   assign rd_active = ~rd_n_sync & hit;

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         wr_prev <= 1'b0;
      end else begin
         wr_prev <= wr_active;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rd_prev <= 1'b0;
      end else begin
         rd_prev <= rd_active;
      end
   end

   // Latch on the trailing edge, when data is settled
   assign wr_strobe = wr_prev & ~wr_active;
   assign rd_strobe = rd_active & ~rd_prev;

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         relay_control_bits <= rlio_pkg::rlio_latch_reset; // RQ10
      end else if (wr_strobe) begin
         relay_control_bits <= data_sync; // RQ3 RQ12
      end
   end

   // Once enabled, only a reset disables the drivers again
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         drivers_enabled <= rlio_pkg::rlio_enable_reset; // RQ10
      end else if (rd_strobe) begin
         drivers_enabled <= 1'b1; // RQ11
      end
   end

   // Readback shows the latch even while drivers are disabled
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         bus_data_out <= 8'h00;
      end else begin
         bus_data_out <= relay_control_bits; // RQ13
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         bus_data_oe_out <= 1'b0;
      end else begin
         bus_data_oe_out <= rd_active; // RQ3
      end
   end

   // Disabled drivers leave every relay on its break contact
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         relay_make_out <= rlio_pkg::rlio_latch_reset; // RQ10
      end else begin
         relay_make_out <= relay_control_bits & {8{drivers_enabled}}; // RQ4
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         relay_break_out <= ~rlio_pkg::rlio_latch_reset; // RQ10
      end else begin
         relay_break_out <= ~(relay_control_bits & {8{drivers_enabled}}); // RQ5
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         relay_led_out <= rlio_pkg::rlio_latch_reset;
      end else begin
         relay_led_out <= relay_control_bits & {8{drivers_enabled}}; // RQ6
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         enable_led_out <= rlio_pkg::rlio_enable_reset;
      end else begin
         enable_led_out <= drivers_enabled; // RQ7
      end
   end
endmodule : rlio_relay_latch

// Two-stage synchroniser; only the second stage feeds logic
module rlio_sync #(
   parameter int width = 1,
   parameter logic [width-1:0] reset_value = '0
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // Asynchronous level and its settled copy
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] meta;

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         meta <= reset_value;
      end else begin
         meta <= async_in;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         sync_out <= reset_value;
      end else begin
         sync_out <= meta;
      end
   end
endmodule : rlio_sync

/* rlio_asserts.sv */
`timescale 1ns/1ps
module rlio_asserts (input wire logic clock_in, reset_in, bus_io_read_n_in,
   input wire logic bus_data_oe_out, enable_led_out,
   input wire logic [9:0] addr_switch_in, bus_addr_in,
   input wire logic [7:0] bus_data_out, relay_make_out, relay_break_out,
   input wire logic [7:0] relay_led_out);
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   property p_brk; relay_break_out == ~relay_make_out; endproperty
   a_brk: assert property (p_brk) else $error("break");
   property p_led; relay_led_out == relay_make_out; endproperty
   a_led: assert property (p_led) else $error("led");
   property p_dis; !enable_led_out |-> relay_make_out == 8'h00; endproperty
   a_dis: assert property (p_dis) else $error("dis");
   property p_en; enable_led_out |=> enable_led_out; endproperty
   a_en: assert property (p_en) else $error("en");
   property p_oe;
      $rose(bus_data_oe_out) |-> bus_addr_in == addr_switch_in;
   endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_rd;
      bus_data_oe_out & enable_led_out |-> bus_data_out == relay_make_out;
   endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_off;
      $rose(bus_io_read_n_in) |-> ##[1:6] !bus_data_oe_out;
   endproperty
   a_off: assert property (p_off) else $error("off");
   property p_on;
      $rose(enable_led_out) |-> !$past(bus_io_read_n_in, 2);
   endproperty
   a_on: assert property (p_on) else $error("on");
endmodule : rlio_asserts
bind rlio_relay_latch rlio_asserts i_rlio_asserts (.*);

/* rlio_host.sv */
`timescale 1ns/1ps
module rlio_host (input wire logic clock_in, input wire logic [7:0] data_in,
   output logic [9:0] addr_out = 10'h000, output logic [7:0] data_out = 8'h00,
   output logic wr_n_out = 1'h1, output logic rd_n_out = 1'h1);
   task cyc(input logic w, input logic [17:0] ad, output logic [7:0] q);
      @(negedge clock_in) {addr_out, data_out} = ad;
      repeat (4) @(negedge clock_in);
      {wr_n_out, rd_n_out} = {!w, w};
      repeat (6) @(negedge clock_in);
      {q, wr_n_out, rd_n_out} = {data_in, 2'h3};
      repeat (6) @(negedge clock_in);
      {addr_out, data_out} = ~ad; // Released lines never keep old value
   endtask : cyc
endmodule : rlio_host

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clock_in = 1'h0, reset_in = 1'h1, wn, rn, oe, en;
   logic [9:0] sw = 10'h310, ad;
   logic [7:0] dw, dr, mk, bk, ld, q;
   int n_errors = 0, checked = 0;
   initial forever #2.5 clock_in = ~clock_in;
   rlio_relay_latch i_rlio_relay_latch (.clock_in, .reset_in,
      .addr_switch_in(sw), .bus_addr_in(ad), .bus_io_write_n_in(wn),
      .bus_io_read_n_in(rn), .bus_data_in(dw), .bus_data_out(dr),
      .bus_data_oe_out(oe), .relay_make_out(mk), .relay_break_out(bk),
      .relay_led_out(ld), .enable_led_out(en));
   rlio_host i_rlio_host (.clock_in, .data_in(dr), .addr_out(ad),
      .data_out(dw), .wr_n_out(wn), .rd_n_out(rn));
   task chk(input logic [7:0] s, e); checked++; n_errors += (s !== e);
      if (s !== e) $display("unexpected at %0t: %h", $time, s);
   endtask : chk
   task t_rst; @(negedge clock_in) reset_in = 1'h1;
      repeat (5) @(negedge clock_in); reset_in = 1'h0;
      chk(mk, 8'h00);
      chk({7'h0, en}, 8'h00);
      $display("reset test end"); endtask : t_rst
   task t_en; i_rlio_host.cyc(1'h1, {sw, 8'h81}, q);
      chk(mk, 8'h00);
      chk(bk, 8'hff);
      i_rlio_host.cyc(1'h0, {sw, 8'h00}, q);
      chk(q, 8'h81);
      chk(mk, 8'h81);
      chk({7'h0, en}, 8'h01);
      chk(bk, 8'h7e);
      chk(ld, 8'h81);
      chk({7'h0, oe}, 8'h00);
      i_rlio_host.cyc(1'h1, {10'h311, 8'h55}, q);
      chk(mk, 8'h81);
      $display("enable test end"); endtask : t_en
   task t_bits; sw = 10'h3f8;
      for (int i = 0; i < 8; i++) begin
         i_rlio_host.cyc(1'h1, {sw, 8'h01 << i}, q);
         chk(mk, 8'h01 << i);
         i_rlio_host.cyc(1'h0, {sw, 8'h00}, q);
         chk(q, 8'h01 << i);
      end
      $display("bit test end"); endtask : t_bits
   task test_done; $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish; endtask : test_done
   initial begin t_rst; t_en; t_bits; t_rst; test_done; end
endmodule : testbench
